//--- rtl/sysclk_consts.svh
// Purpose: Offsets, fields, reset values and counts of the clock and mode control
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Operation list below
//
// Operation
// - High select uses undivided fast clock
// - Divider code picks slow or fast/64 to /2
// - Moving to slow clock stops fast oscillator
// - Watchdog always-on removes deep stop mode
// - Halt, no idle, no watchdog/detector: deep stop
// - Detector enabled forbids deep stop mode
// - Halt, no idle, watchdog or detector: light stop
// - Halt, idle, sysclk off: idle clock off
// - Halt, idle, sysclk on: idle clock on
// - Detector enabled keeps detector and slow clock
// - Slow ready rises after slow oscillator settles
// - Fast ready rises 16 cycles after start
// - Fast ready low in stop and idle-off
// - CPU runs only in normal and slow modes
// - Entering low power sets flag, clears timeout
// - Port edge, interrupt or watchdog wake
`ifndef SYSCLK_CONSTS_SVH
`define SYSCLK_CONSTS_SVH

`define OFS_CLOCK_MODE_SELECT 3'h0
`define OFS_IDLE_CLOCK_AND_RESET_FLAGS 3'h1
`define OFS_EVENT_STATUS 3'h2
`define OFS_EVENT_MASK 3'h3
`define OFS_POWER_CONTROL 3'h4

`define RST_CLK_DIVIDER_SELECT 3'h6
`define RST_IDLE_ON_HALT_ENABLE 1'h1
`define RST_SYS_CLK_HIGH_SELECT 1'h0
`define RST_SYSCLK_ON_IN_IDLE 1'h0
`define RST_RESET_FLAGS 3'h0
`define RST_DIV_EXP 3'h2

`define EVT_MODE_ENTER 0
`define EVT_WAKE 1
`define EVT_HIGH_READY 2
`define EVT_LOW_READY 3

`define HIGH_READY_CYCLES 5'h10
`define LOW_READY_TICKS 2'h2

`endif

//--- rtl/sysclk_pkg.sv
// Purpose: Types shared by the clock and mode control
// Assumes: Nothing beyond the constants header
// Notes: Operating state is one packed struct
`default_nettype none
package sysclk_pkg;

  typedef enum logic [2:0] {
    run_mode,
    deep_stop_mode,
    light_stop_mode,
    idle_clock_off_mode,
    idle_clock_on_mode
  } mode_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic port_fall;
    logic sys_irq;
    logic wdt_overflow;
  } wake_t;

  typedef struct packed {
    mode_t mode;
    logic sys_clk_high_select;
    logic [2:0] clk_divider_select;
    logic idle_on_halt_enable;
    logic sysclk_on_in_idle;
    logic low_volt_detect_enable;
    logic [2:0] reset_flags;
    logic [3:0] status;
    logic [3:0] mask;
    logic high_osc_ready;
    logic [4:0] high_cnt;
    logic low_osc_ready;
    logic [1:0] low_cnt;
    logic fast_en;
    logic slow_en;
    logic [2:0] cur_exp;
    logic cur_slow;
    logic [5:0] div_cnt;
    logic sysclk;
    logic cpu_run;
    logic pdf_set;
    logic to_clr;
    logic wdt_run;
    logic lvd_keep;
    logic irq;
    logic [7:0] rdata;
  } state_t;

endpackage : sysclk_pkg
`default_nettype wire

//--- rtl/sysclk_mode_control.sv
// Purpose: System clock source selection and halt-driven low power modes
// Assumes: clk runs at twice the fast clock, so high select gives the fast clock itself;
//   slow_tick marks slow clock edges
// Notes: System clock is produced as a register so every phase is whole
//
// Local design decisions: the placing of the registers and the strobed register port.
`include "sysclk_consts.svh"
`default_nettype none
module sysclk_mode_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire sysclk_pkg::bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic halt,
  input wire sysclk_pkg::wake_t wake,
  input wire logic slow_tick,
  input wire logic wdt_enable,
  input wire logic wdt_always_on,
  output logic sys_clk,
  output logic cpu_run,
  output logic fast_osc_en,
  output logic slow_osc_en,
  output logic high_osc_ready,
  output logic low_osc_ready,
  output logic wdt_run,
  output logic lvd_keep,
  output logic pdf_set,
  output logic to_clr,
  output logic irq,
  output var sysclk_pkg::mode_t mode
);

  sysclk_pkg::state_t s_r;
  sysclk_pkg::state_t s_nxt;

  logic req_slow;
  logic [2:0] req_exp;
  logic clk_tick;
  logic clk_stop;
  logic wake_any;
  logic [3:0] evt;

  // Requested source from the select bit and divider code
  always_comb
  begin
    req_slow = !s_r.sys_clk_high_select && (s_r.clk_divider_select < 3'h2);
    if (s_r.sys_clk_high_select)
    begin
      req_exp = 3'h0;
    end
    else
    begin
      req_exp = 3'(4'h8 - {1'b0, s_r.clk_divider_select});
    end
  end

  assign wake_any = wake.port_fall || wake.sys_irq || wake.wdt_overflow;
  assign clk_stop = (s_r.mode == sysclk_pkg::deep_stop_mode)
                 || (s_r.mode == sysclk_pkg::light_stop_mode)
                 || (s_r.mode == sysclk_pkg::idle_clock_off_mode);
  assign clk_tick = s_r.cur_slow ? slow_tick
                  : (s_r.div_cnt == 6'((7'h01 << s_r.cur_exp) - 7'h01));

  always_comb
  begin
    s_nxt = s_r;
    evt = 4'h0;
    s_nxt.pdf_set = 1'b0;
    s_nxt.to_clr = 1'b0;

    // Mode sequencing
    if (s_r.mode == sysclk_pkg::run_mode)
    begin
      if (halt)
      begin
        s_nxt.pdf_set = 1'b1;
        s_nxt.to_clr = 1'b1;
        evt[`EVT_MODE_ENTER] = 1'b1;
        if (s_r.idle_on_halt_enable)
        begin
          if (s_r.sysclk_on_in_idle)
          begin
            s_nxt.mode = sysclk_pkg::idle_clock_on_mode;
          end
          else
          begin
            s_nxt.mode = sysclk_pkg::idle_clock_off_mode;
          end
        end
        else if (wdt_enable || wdt_always_on || s_r.low_volt_detect_enable)
        begin
          s_nxt.mode = sysclk_pkg::light_stop_mode;
        end
        else
        begin
          s_nxt.mode = sysclk_pkg::deep_stop_mode;
        end
      end
    end
    else if (wake_any)
    begin
      s_nxt.mode = sysclk_pkg::run_mode;
      evt[`EVT_WAKE] = 1'b1;
    end

    s_nxt.cpu_run = (s_nxt.mode == sysclk_pkg::run_mode);
    s_nxt.slow_en = (s_nxt.mode != sysclk_pkg::deep_stop_mode) || wdt_always_on;
    s_nxt.wdt_run = (s_nxt.mode != sysclk_pkg::deep_stop_mode) && (wdt_enable || wdt_always_on);
    s_nxt.lvd_keep = s_r.low_volt_detect_enable;

    // Clock generator: a source change is taken only at the end of a whole low phase
    if (s_r.cur_slow)
    begin
      s_nxt.div_cnt = 6'h00;
    end
    else if (clk_tick)
    begin
      s_nxt.div_cnt = 6'h00;
    end
    else
    begin
      s_nxt.div_cnt = 6'(s_r.div_cnt + 6'h01);
    end
    if (clk_tick)
    begin
      if (s_r.sysclk)
      begin
        s_nxt.sysclk = 1'b0;
      end
      else if (!clk_stop)
      begin
        s_nxt.sysclk = 1'b1;
        s_nxt.cur_slow = req_slow;
        s_nxt.cur_exp = req_exp;
        s_nxt.div_cnt = 6'h00;
      end
    end

    // Fast oscillator held only while a fast-derived clock is wanted or still active;
    // uses the source just taken so it stops in the same cycle as the move to slow
    case (s_nxt.mode)
      sysclk_pkg::run_mode:
      begin
        s_nxt.fast_en = !(req_slow && s_nxt.cur_slow);
      end
      sysclk_pkg::idle_clock_on_mode:
      begin
        s_nxt.fast_en = !s_nxt.cur_slow;
      end
      default:
      begin
        s_nxt.fast_en = 1'b0;
      end
    endcase

    // Ready flags restart whenever their oscillator is off
    if (!s_nxt.fast_en)
    begin
      s_nxt.high_osc_ready = 1'b0;
      s_nxt.high_cnt = 5'h00;
    end
    else if (!s_r.high_osc_ready)
    begin
      s_nxt.high_cnt = 5'(s_r.high_cnt + 5'h01);
      if (s_r.high_cnt == 5'(`HIGH_READY_CYCLES - 5'h01))
      begin
        s_nxt.high_osc_ready = 1'b1;
        evt[`EVT_HIGH_READY] = 1'b1;
      end
    end
    if (!s_nxt.slow_en)
    begin
      s_nxt.low_osc_ready = 1'b0;
      s_nxt.low_cnt = 2'h0;
    end
    else if (!s_r.low_osc_ready && slow_tick)
    begin
      s_nxt.low_cnt = 2'(s_r.low_cnt + 2'h1);
      if (s_r.low_cnt == 2'(`LOW_READY_TICKS - 2'h1))
      begin
        s_nxt.low_osc_ready = 1'b1;
        evt[`EVT_LOW_READY] = 1'b1;
      end
    end

    // Register writes; read-only and unused bits are not stored
    s_nxt.status = s_r.status;
    if (bus_req.wr)
    begin
      if (bus_req.addr == `OFS_CLOCK_MODE_SELECT)
      begin
        s_nxt.clk_divider_select = bus_req.wdata[7:5];
        s_nxt.idle_on_halt_enable = bus_req.wdata[1];
        s_nxt.sys_clk_high_select = bus_req.wdata[0];
      end
      else if (bus_req.addr == `OFS_IDLE_CLOCK_AND_RESET_FLAGS)
      begin
        s_nxt.sysclk_on_in_idle = bus_req.wdata[7];
        s_nxt.reset_flags = bus_req.wdata[2:0];
      end
      else if (bus_req.addr == `OFS_EVENT_STATUS)
      begin
        s_nxt.status = s_r.status & ~bus_req.wdata[3:0];
      end
      else if (bus_req.addr == `OFS_EVENT_MASK)
      begin
        s_nxt.mask = bus_req.wdata[3:0];
      end
      else if (bus_req.addr == `OFS_POWER_CONTROL)
      begin
        s_nxt.low_volt_detect_enable = bus_req.wdata[0];
      end
    end
    // Set wins over a simultaneous clear
    s_nxt.status = s_nxt.status | evt;
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);

    s_nxt.rdata = 8'h00;
    if (bus_req.rd)
    begin
      if (bus_req.addr == `OFS_CLOCK_MODE_SELECT)
      begin
        s_nxt.rdata = {s_r.clk_divider_select, 1'b0, s_r.low_osc_ready,
                       s_r.high_osc_ready, s_r.idle_on_halt_enable, s_r.sys_clk_high_select};
      end
      else if (bus_req.addr == `OFS_IDLE_CLOCK_AND_RESET_FLAGS)
      begin
        s_nxt.rdata = {s_r.sysclk_on_in_idle, 4'h0, s_r.reset_flags};
      end
      else if (bus_req.addr == `OFS_EVENT_STATUS)
      begin
        s_nxt.rdata = {4'h0, s_r.status};
      end
      else if (bus_req.addr == `OFS_EVENT_MASK)
      begin
        s_nxt.rdata = {4'h0, s_r.mask};
      end
      else if (bus_req.addr == `OFS_POWER_CONTROL)
      begin
        s_nxt.rdata = {7'h00, s_r.low_volt_detect_enable};
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.mode <= sysclk_pkg::run_mode;
      s_r.clk_divider_select <= `RST_CLK_DIVIDER_SELECT;
      s_r.idle_on_halt_enable <= `RST_IDLE_ON_HALT_ENABLE;
      s_r.sys_clk_high_select <= `RST_SYS_CLK_HIGH_SELECT;
      s_r.sysclk_on_in_idle <= `RST_SYSCLK_ON_IN_IDLE;
      s_r.reset_flags <= `RST_RESET_FLAGS;
      s_r.cur_exp <= `RST_DIV_EXP;
      s_r.fast_en <= 1'b1;
      s_r.slow_en <= 1'b1;
      s_r.cpu_run <= 1'b1;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign sys_clk = s_r.sysclk;
  assign cpu_run = s_r.cpu_run;
  assign fast_osc_en = s_r.fast_en;
  assign slow_osc_en = s_r.slow_en;
  assign high_osc_ready = s_r.high_osc_ready;
  assign low_osc_ready = s_r.low_osc_ready;
  assign wdt_run = s_r.wdt_run;
  assign lvd_keep = s_r.lvd_keep;
  assign pdf_set = s_r.pdf_set;
  assign to_clr = s_r.to_clr;
  assign irq = s_r.irq;
  assign mode = s_r.mode;

  // Checks
  property p_light_entry;
    @(posedge clk) disable iff (rst)
    (ce && s_r.mode == sysclk_pkg::run_mode && halt && !s_r.idle_on_halt_enable
     && (wdt_enable || wdt_always_on || s_r.low_volt_detect_enable))
    |=> (s_r.mode == sysclk_pkg::light_stop_mode);
  endproperty
  a_light_entry: assert property (p_light_entry) else $error("light stop not entered");

  property p_deep_entry;
    @(posedge clk) disable iff (rst)
    (ce && s_r.mode == sysclk_pkg::run_mode && halt && !s_r.idle_on_halt_enable
     && !wdt_enable && !wdt_always_on && !s_r.low_volt_detect_enable)
    |=> (s_r.mode == sysclk_pkg::deep_stop_mode) && !s_r.wdt_run && !s_r.cpu_run;
  endproperty
  a_deep_entry: assert property (p_deep_entry) else $error("deep stop not entered");

  property p_no_deep_always_on;
    @(posedge clk) disable iff (rst)
    (ce && halt && wdt_always_on) |=> (s_r.mode != sysclk_pkg::deep_stop_mode);
  endproperty
  a_no_deep_always_on: assert property (p_no_deep_always_on) else $error("deep stop wdt");

  property p_idle_entry;
    @(posedge clk) disable iff (rst)
    (ce && s_r.mode == sysclk_pkg::run_mode && halt && s_r.idle_on_halt_enable)
    |=> (s_r.mode == ($past(s_r.sysclk_on_in_idle) ? sysclk_pkg::idle_clock_on_mode
                                                   : sysclk_pkg::idle_clock_off_mode));
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("wrong idle mode");

  property p_high_ready_low;
    @(posedge clk) disable iff (rst)
    (s_r.mode inside {sysclk_pkg::deep_stop_mode, sysclk_pkg::light_stop_mode,
                      sysclk_pkg::idle_clock_off_mode}) |-> !s_r.high_osc_ready;
  endproperty
  a_high_ready_low: assert property (p_high_ready_low) else $error("fast ready in stop");

  property p_detector_keeps_slow;
    @(posedge clk) disable iff (rst)
    (s_r.low_volt_detect_enable && s_r.mode != sysclk_pkg::run_mode) |-> s_r.slow_en;
  endproperty
  a_detector_keeps_slow: assert property (p_detector_keeps_slow) else $error("slow off");

  property p_entry_flags;
    @(posedge clk) disable iff (rst)
    (ce && s_r.mode == sysclk_pkg::run_mode && halt)
    |=> s_r.pdf_set && s_r.to_clr ##1 !s_r.pdf_set;
  endproperty
  a_entry_flags: assert property (p_entry_flags) else $error("flags not pulsed");

  property p_wake;
    @(posedge clk) disable iff (rst)
    (ce && s_r.mode != sysclk_pkg::run_mode
     && (wake.port_fall || wake.sys_irq || wake.wdt_overflow))
    |=> (s_r.mode == sysclk_pkg::run_mode) && s_r.cpu_run;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");

  property p_slow_stops_fast;
    @(posedge clk) disable iff (rst)
    (s_r.cur_slow && s_r.mode == sysclk_pkg::run_mode && !s_r.sys_clk_high_select
     && s_r.clk_divider_select < 3'h2) |-> !s_r.fast_en;
  endproperty
  a_slow_stops_fast: assert property (p_slow_stops_fast) else $error("fast osc left on");

  property p_reserved_zero;
    @(posedge clk) disable iff (rst)
    (ce && bus_req.rd && bus_req.addr == `OFS_CLOCK_MODE_SELECT) |=> (s_r.rdata[4] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_stopped_no_rise;
    @(posedge clk) disable iff (rst)
    (ce && (s_r.mode inside {sysclk_pkg::deep_stop_mode, sysclk_pkg::light_stop_mode,
                             sysclk_pkg::idle_clock_off_mode})) |=> !$rose(s_r.sysclk);
  endproperty
  a_stopped_no_rise: assert property (p_stopped_no_rise) else $error("sys clock in stop");

  property p_deep_slow_off;
    @(posedge clk) disable iff (rst)
    (s_r.mode == sysclk_pkg::deep_stop_mode && !wdt_always_on)
    |-> !s_r.slow_en && !s_r.low_osc_ready && !s_r.wdt_run;
  endproperty
  a_deep_slow_off: assert property (p_deep_slow_off) else $error("slow on in deep");

  property p_cpu_halted;
    @(posedge clk) disable iff (rst)
    (s_r.mode != sysclk_pkg::run_mode) |-> !s_r.cpu_run;
  endproperty
  a_cpu_halted: assert property (p_cpu_halted) else $error("cpu runs in low power");

  property p_high_ready_wait;
    @(posedge clk) disable iff (rst)
    (ce && !s_r.fast_en) |=> (!s_r.high_osc_ready) [*8];
  endproperty
  a_high_ready_wait: assert property (p_high_ready_wait) else $error("ready early");

  property p_ctrl_reserved;
    @(posedge clk) disable iff (rst)
    (ce && bus_req.rd && bus_req.addr == `OFS_IDLE_CLOCK_AND_RESET_FLAGS)
    |=> (s_r.rdata[6:3] == 4'h0);
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("ctrl bits set");

endmodule : sysclk_mode_control
`default_nettype wire

//--- testbench/tb.sv
// Purpose: Self-checking bench for the clock and mode control
// Assumes: Outputs settle 1 ns after the rising edge
// Notes: Slow tick every 5 cycles keeps slow phases short
`include "sysclk_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ce, halt, slow_tick, wdt_enable, wdt_always_on;
  sysclk_pkg::bus_req_t bus_req;
  sysclk_pkg::wake_t wake;
  sysclk_pkg::mode_t mode, em;
  logic [7:0] rdata, v, seed;
  logic sys_clk, cpu_run, fast_osc_en, slow_osc_en, high_osc_ready, low_osc_ready;
  logic wdt_run, lvd_keep, pdf_set, to_clr, irq;
  int err_total, n_tests, n, tick_cnt;

  sysclk_mode_control dut (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .bus_req(bus_req),
    .rdata(rdata),
    .halt(halt),
    .wake(wake),
    .slow_tick(slow_tick),
    .wdt_enable(wdt_enable),
    .wdt_always_on(wdt_always_on),
    .sys_clk(sys_clk),
    .cpu_run(cpu_run),
    .fast_osc_en(fast_osc_en),
    .slow_osc_en(slow_osc_en),
    .high_osc_ready(high_osc_ready),
    .low_osc_ready(low_osc_ready),
    .wdt_run(wdt_run),
    .lvd_keep(lvd_keep),
    .pdf_set(pdf_set),
    .to_clr(to_clr),
    .irq(irq),
    .mode(mode)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Free-running slow tick, one pulse every 5 cycles
  always @(posedge clk)
  begin
    tick_cnt <= (tick_cnt == 4) ? 0 : tick_cnt + 1;
    slow_tick <= (tick_cnt == 4);
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tmo(input string nm);
    chk(nm, 8'h01, 8'h00);
    end_sim();
  endtask : tmo

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rdc

  task automatic until_clk(input logic lv, inout int k);
    while (sys_clk !== lv)
    begin
      @(negedge clk);
      k++;
      if (k > 700)
        tmo("sys_clk wait");
    end
  endtask : until_clk

  // Second high phase is measured: the first may predate the switch
  task automatic period(input int e, input string nm);
    int k;
    k = 0;
    @(negedge clk);
    repeat (2)
    begin
      until_clk(1'b0, k);
      until_clk(1'b1, k);
      n = 0;
      while (sys_clk === 1'b1 && n < 300)
      begin
        @(negedge clk);
        n++;
      end
      if (n >= 300)
        tmo("sys_clk high");
    end
    chk(nm, 8'(e), 8'(n));
  endtask : period

  task automatic rtime;
    int k;
    k = 0;
    while (fast_osc_en !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    n = 0;
    while (high_osc_ready !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (k >= 40 || n >= 40)
      tmo("ready wait");
    chk("high ready delay", 8'h01, {7'h00, n >= 15 && n <= 16});
  endtask : rtime

  initial
  begin
    #500us;
    tmo("run time");
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    halt = 1'b0;
    wake = '0;
    bus_req = '0;
    slow_tick = 1'b0;
    tick_cnt = 0;
    wdt_enable = 1'b0;
    wdt_always_on = 1'b0;
    seed = 8'h07;
    err_total = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (60) @(posedge clk);
    rdc(3'h0, 8'hce, "clock_mode_select"); // Reset view
    rdc(3'h1, 8'h00, "idle_clock_and_reset_flags"); // Reset view
    rdc(3'h4, 8'h00, "power control"); // Reset view
    wr(3'h5, 8'hff);
    rdc(3'h5, 8'h00, "unmapped"); // Unmapped place
    repeat (4)
    begin
      seed = lfsr(seed);
      wr(3'h1, seed);
      rdc(3'h1, seed & 8'h87, "flags random"); // Stored bits only
    end
    wr(3'h1, 8'h00);
    wr(3'h0, 8'hff);
    rdc(3'h0, 8'hef, "clock_mode_select ones"); // Read-only bits kept
    period(1, "fast half"); // Undivided source
    for (int c = 7; c >= 0; c--)
    begin
      wr(3'h0, {3'(c), 5'h02});
      period((c < 2) ? 5 : (1 << (8 - c)), "divided half"); // Each code
    end
    chk("fast off in slow", 8'h00, {7'h00, fast_osc_en}); // Slow mode
    wr(3'h0, 8'hc2);
    rtime(); // Back to fast
    for (int i = 0; i < 32; i++)
    begin
      @(posedge clk);
      wdt_enable <= i[2];
      wdt_always_on <= i[4];
      wr(3'h0, {3'h6, 3'h0, i[0], 1'b0});
      wr(3'h1, {i[1], 7'h00});
      wr(3'h4, {7'h00, i[3]});
      wr(3'h3, (i > 0) ? 8'h03 : 8'h00);
      if (i[0])
        em = i[1] ? sysclk_pkg::idle_clock_on_mode : sysclk_pkg::idle_clock_off_mode;
      else if (i[2] | i[3] | i[4])
        em = sysclk_pkg::light_stop_mode;
      else
        em = sysclk_pkg::deep_stop_mode;
      @(posedge clk);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      #1;
      chk("mode", {5'h00, em}, {5'h00, mode}); // Halt decode
      chk("entry", 8'h03, {5'h00, cpu_run, pdf_set, to_clr}); // Entry
      chk("slow on", {7'h00, em != sysclk_pkg::deep_stop_mode}, {7'h00, slow_osc_en});
      chk("lvd keep", {7'h00, i[3]}, {7'h00, lvd_keep}); // Detector kept
      if (em != sysclk_pkg::idle_clock_on_mode)
        chk("fast off", 8'h00, {6'h00, fast_osc_en, high_osc_ready}); // Stopped
      if (em == sysclk_pkg::deep_stop_mode)
        chk("wdt off", 8'h00, {7'h00, wdt_run}); // Deep stop
      repeat (3) @(posedge clk);
      #1;
      chk("held", {2'h0, em, 3'h0}, {2'h0, mode, pdf_set, to_clr, cpu_run});
      seed = lfsr(seed);
      @(posedge clk);
      wake <= sysclk_pkg::wake_t'(3'h1 << (seed % 8'h03));
      @(posedge clk);
      wake <= '0;
      #1;
      chk("woken", {4'h0, sysclk_pkg::run_mode, 1'b1}, {4'h0, mode, cpu_run});
      if (em != sysclk_pkg::idle_clock_on_mode)
        rtime(); // Restart after wake
      rd(3'h2, v);
      chk("status", 8'h03, v & 8'h03); // Entry and wake events
      chk("irq", {7'h00, i > 0}, {7'h00, irq}); // Masked or raised
      wr(3'h2, 8'h03);
      repeat (2) @(posedge clk);
      #1;
      chk("irq cleared", 8'h00, {7'h00, irq}); // Write one clears
    end
    end_sim();
  end
endmodule : tb
`default_nettype wire
